// ### hw/shift_out.sv
// serial shift-out engine: sends a word on a data pin with a generated clock
// Overview of operation
// - two-bit option picks bit order (msb/lsb) and active clock edge (fall/rise)
// - without explicit count, send 8, 16 or 32 bits by source size
// - an explicit bit count replaces the default width, clamped to 1 up to the word width
// - half period defaults to two idle instruction times, else programmed microseconds
// - clock pin goes to its idle level before the first bit
// - bits of the word leave on the data pin; clock made here
// - idle clock low for rising options, high for falling; returns after
`timescale 1ns/1ps
`include "shift_out_consts.svh"
module shift_out
	import shift_out_pkg::*;
#(
	parameter int DATA_W  = 32,
	parameter int DELAY_W = 16
) (
	// clock and reset
	input  wire logic                   clk_sys_in,
	input  wire logic                   sys_rst_in,
	// request stream
	input  wire logic                   req_valid_in,
	output logic                        req_ready_out,
	input  wire logic [DATA_W-1:0]      req_data_in,
	input  wire logic [1:0]             req_option_in,
	input  wire shift_out_pkg::src_size_e req_size_in,
	input  wire logic                   req_bits_en_in,
	input  wire logic [6:0]             req_bits_in,
	input  wire logic                   req_delay_en_in,
	input  wire logic [DELAY_W-1:0]     req_delay_us_in,
	// serial pins
	output logic                        sdata_out,
	output logic                        sclk_out,
	// status
	output logic                        busy_out,
	output logic                        done_out
);
	import shift_out_pkg::*;

	localparam int REQ_W = DATA_W + 2 + 2 + 1 + 7 + 1 + DELAY_W;
	localparam int CNT_W = DELAY_W + 8;

	wire [REQ_W-1:0] req_word = {req_data_in, req_option_in, req_size_in, req_bits_en_in,
		req_bits_in, req_delay_en_in, req_delay_us_in};
	logic             q_valid;
	logic             q_ready;
	logic [REQ_W-1:0] q_word;

	shift_out_buf #(
		.WIDTH(REQ_W)
	) u_buf (
		.clk_sys_in   (clk_sys_in),
		.sys_rst_in   (sys_rst_in),
		.in_valid_in  (req_valid_in),
		.in_ready_out (req_ready_out),
		.in_data_in   (req_word),
		.out_valid_out(q_valid),
		.out_ready_in (q_ready),
		.out_data_out (q_word)
	);

	// unpack the queued request
	wire [DATA_W-1:0]  q_data     = q_word[REQ_W-1 -: DATA_W];
	wire [1:0]         q_option   = q_word[DELAY_W+11 +: 2];
	wire [1:0]         q_size     = q_word[DELAY_W+9 +: 2];
	wire               q_bits_en  = q_word[DELAY_W+8];
	wire [6:0]         q_bits     = q_word[DELAY_W+1 +: 7];
	wire               q_delay_en = q_word[DELAY_W];
	wire [DELAY_W-1:0] q_delay    = q_word[DELAY_W-1:0];

	wire [6:0] dflt_bits = (q_size == `SIZE_BYTE) ? `BITS_BYTE :
		(q_size == `SIZE_WORD) ? `BITS_WORD : `BITS_LONG;
	// a count of zero or beyond the word width is clamped to keep the engine sane
	wire [6:0] raw_bits  = q_bits_en ? q_bits : dflt_bits;
	wire [6:0] max_bits  = 7'(DATA_W);
	wire [6:0] use_bits  = (raw_bits == 7'h00) ? 7'h01 :
		(raw_bits > max_bits) ? max_bits : raw_bits;
	wire [CNT_W-1:0] us_cycles = CNT_W'(q_delay) * CNT_W'(`CYCLES_PER_US);
	wire [CNT_W-1:0] half_cyc  = (q_delay_en && q_delay != '0) ? us_cycles
		: CNT_W'(`DEF_HALF_CYCLES);
	wire             q_lsb     = q_option[`OPT_LSB_BIT];
	wire             q_rise    = q_option[`OPT_RISE_BIT];
	// msb-first starts from the top of the selected count
	wire [DATA_W-1:0] aligned  = q_lsb ? q_data
		: (q_data << (7'(DATA_W) - use_bits));

	shift_state_e     state_ff;
	logic [DATA_W-1:0] shreg_ff;
	logic              lsb_ff;
	logic              idle_lvl_ff;
	logic [6:0]        left_ff;
	logic [CNT_W-1:0]  half_ff;
	logic [CNT_W-1:0]  tmr_ff;
	logic              sdata_ff;
	logic              sclk_ff;
	logic              done_ff;

	wire tmr_end  = (tmr_ff == CNT_W'(1));
	wire last_bit = (left_ff == 7'h01);
	wire cur_bit  = lsb_ff ? shreg_ff[0] : shreg_ff[DATA_W-1];
	assign q_ready  = (state_ff == ST_IDLE);
	assign sdata_out = sdata_ff;
	assign sclk_out  = sclk_ff;
	assign busy_out  = (state_ff != ST_IDLE);
	assign done_out  = done_ff;

	always_ff @(posedge clk_sys_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			state_ff    <= ST_IDLE;
			shreg_ff    <= '0;
			lsb_ff      <= 1'b0;
			idle_lvl_ff <= 1'b1;
			left_ff     <= 7'h00;
			half_ff     <= '0;
			tmr_ff      <= '0;
			sdata_ff    <= 1'b0;
			sclk_ff     <= 1'b1;
			done_ff     <= 1'b0;
		end
		else
		begin
			done_ff <= 1'b0;
			case (state_ff)
				ST_IDLE:
				begin
					if (q_valid)
					begin
						shreg_ff    <= aligned;
						lsb_ff      <= q_lsb;
						idle_lvl_ff <= ~q_rise;
						sclk_ff     <= ~q_rise;
						left_ff     <= use_bits;
						half_ff     <= half_cyc;
						tmr_ff      <= half_cyc;
						state_ff    <= ST_SETUP;
					end
				end
				ST_SETUP:
				begin
					// first bit placed one half period less one cycle ahead of the active edge
					sdata_ff <= cur_bit;
					if (tmr_end)
					begin
						sclk_ff  <= ~idle_lvl_ff;
						tmr_ff   <= half_ff;
						state_ff <= ST_LEAD;
					end
					else
						tmr_ff <= tmr_ff - CNT_W'(1);
				end
				ST_LEAD:
				begin
					if (tmr_end)
					begin
						sclk_ff  <= idle_lvl_ff;
						tmr_ff   <= half_ff;
						state_ff <= ST_TRAIL;
					end
					else
						tmr_ff <= tmr_ff - CNT_W'(1);
				end
				ST_TRAIL:
				begin
					if (tmr_end)
					begin
						if (last_bit)
						begin
							done_ff  <= 1'b1;
							state_ff <= ST_IDLE;
						end
						else
						begin
							// data changes only while clock sits idle
							shreg_ff <= lsb_ff ? (shreg_ff >> 1) : (shreg_ff << 1);
							left_ff  <= left_ff - 7'h01;
							tmr_ff   <= half_ff;
							state_ff <= ST_SETUP;
						end
					end
					else
						tmr_ff <= tmr_ff - CNT_W'(1);
				end
				default:
					state_ff <= ST_IDLE;
			endcase
		end
	end
endmodule

// ### hw/shift_out_consts.svh
// timing and option constants for the serial shift-out engine
`ifndef SHIFT_OUT_CONSTS_SVH
`define SHIFT_OUT_CONSTS_SVH
`define CLK_PERIOD_PS      32'd5000
`define CYCLES_PER_US      32'd200
`define NOP_TIME_PS        32'd5000
`define DEF_HALF_CYCLES    ((2 * `NOP_TIME_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define OPT_LSB_BIT        1
`define OPT_RISE_BIT       0
`define SIZE_BYTE          2'h0
`define SIZE_WORD          2'h1
`define SIZE_LONG          2'h2
`define BITS_BYTE          7'h08
`define BITS_WORD          7'h10
`define BITS_LONG          7'h20
`endif

// ### hw/shift_out_pkg.sv
// types for the serial shift-out engine
package shift_out_pkg;
	typedef enum logic [1:0] {
		SIZE_8  = 2'h0,
		SIZE_16 = 2'h1,
		SIZE_32 = 2'h2
	} src_size_e;
	typedef enum {
		ST_IDLE,
		ST_SETUP,
		ST_LEAD,
		ST_TRAIL
	} shift_state_e;
endpackage

// ### hw/shift_out_buf.sv
// two-entry valid/ready buffer for transfer requests
`timescale 1ns/1ps
module shift_out_buf #(
	parameter int WIDTH = 8
) (
	// clock and reset
	input  wire logic             clk_sys_in,
	input  wire logic             sys_rst_in,
	// fill side
	input  wire logic             in_valid_in,
	output logic                  in_ready_out,
	input  wire logic [WIDTH-1:0] in_data_in,
	// drain side
	output logic                  out_valid_out,
	input  wire logic             out_ready_in,
	output logic [WIDTH-1:0]      out_data_out
);
	logic [WIDTH-1:0] mem_ff [2];
	logic             wr_ptr_ff;
	logic             rd_ptr_ff;
	logic [1:0]       count_ff;
	wire              do_wr = in_valid_in && in_ready_out;
	wire              do_rd = out_valid_out && out_ready_in;
	wire [1:0]        nxt_count = count_ff + {1'b0, do_wr} - {1'b0, do_rd};

	assign in_ready_out  = (count_ff != 2'h2);
	assign out_valid_out = (count_ff != 2'h0);
	assign out_data_out  = mem_ff[rd_ptr_ff];

	always_ff @(posedge clk_sys_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			wr_ptr_ff <= 1'b0;
			rd_ptr_ff <= 1'b0;
			count_ff  <= 2'h0;
		end
		else
		begin
			wr_ptr_ff <= wr_ptr_ff ^ do_wr;
			rd_ptr_ff <= rd_ptr_ff ^ do_rd;
			count_ff  <= nxt_count;
		end
	end

	always_ff @(posedge clk_sys_in)
	begin
		if (do_wr)
			mem_ff[wr_ptr_ff] <= in_data_in;
	end
endmodule

// ### sim/shift_rx_model.sv
// receiving chip: takes data on the active clock edge
`timescale 1ns/1ps
module shift_rx_model (
	// clock, clear, mode
	input  wire logic       clk_sys_in,
	input  wire logic       clr_in,
	input  wire logic [1:0] option_in,
	// serial pins
	input  wire logic       sclk_in,
	input  wire logic       sdata_in,
	// capture
	output logic [31:0]     word_out,
	output logic [6:0]      cnt_out
);
	logic last_ff;
	// the move to idle level is never an active edge
	wire  act = option_in[0] ? sclk_in & ~last_ff : ~sclk_in & last_ff;
	always_ff @(posedge clk_sys_in)
	begin
		last_ff <= sclk_in;
		if (clr_in)
		begin
			cnt_out  <= 7'h00;
			word_out <= 32'h0;
		end
		else if (act)
		begin
			cnt_out  <= cnt_out + 7'h01;
			word_out <= option_in[1] ? {sdata_in, word_out[31:1]} : {word_out[30:0], sdata_in};
		end
	end
endmodule

// ### sim/shift_out_assertions.sv
// port checks for the shift-out engine
`timescale 1ns/1ps
module shift_out_assertions (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic sys_rst_in,
	// watched ports
	input wire logic req_ready_out,
	input wire logic sdata_out,
	input wire logic sclk_out,
	input wire logic busy_out,
	input wire logic done_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (sys_rst_in);
	done_pulse_a: assert property (done_out |=> !done_out) else $error("done too long");
	done_end_a: assert property ($fell(busy_out) |-> done_out) else $error("no done");
	done_idle_a: assert property (done_out |-> !busy_out) else $error("done while busy");
	data_hold_a: assert property (busy_out && $changed(sdata_out) |-> $stable(sclk_out))
		else $error("data moved with clock");
	clock_phase_a: assert property (busy_out && $changed(sclk_out) |=> $stable(sclk_out))
		else $error("clock phase short");
	idle_still_a: assert property (!busy_out && !$past(busy_out) |-> $stable(sclk_out))
		else $error("clock moved idle");
	min_bit_a: assert property ($rose(busy_out) |-> busy_out[*5]) else $error("bit short");
	done_bound_a: assert property ($rose(busy_out) |-> ##[5:1000] done_out)
		else $error("done late");
	cover property (done_out);
	cover property (!req_ready_out);
	cover property (busy_out && $rose(sclk_out));
endmodule
bind shift_out shift_out_assertions u_shift_out_assertions (.clk_sys_in(clk_sys_in),
	.sys_rst_in(sys_rst_in), .req_ready_out(req_ready_out), .sdata_out(sdata_out),
	.sclk_out(sclk_out), .busy_out(busy_out), .done_out(done_out));

// ### sim/test_shift_out.sv
// self-checking bench for the serial shift-out engine
`timescale 1ns/1ps
`define CHK(n, e, s) begin cmp_count++; if ((e) !== (s)) begin bad_count++; \
	$display("wrong value %s exp %0h got %0h", n, e, s); end end
module test_shift_out;
	import shift_out_pkg::*;
	typedef struct packed {
		logic [1:0]  opt;
		logic [1:0]  size;
		logic        ben;
		logic [6:0]  bits;
		logic [31:0] data;
		logic [6:0]  n;
	} row_s;
	row_s rows[6] = '{
		'{2'h0, 2'h0, 1'h0, 7'h00, 32'ha5c3_1e96, 7'h08},
		'{2'h1, 2'h1, 1'h0, 7'h00, 32'h3c5a_9e71, 7'h10},
		'{2'h2, 2'h2, 1'h0, 7'h00, 32'h8123_4567, 7'h20},
		'{2'h3, 2'h0, 1'h1, 7'h09, 32'hfedc_ba98, 7'h09},
		'{2'h0, 2'h2, 1'h1, 7'h00, 32'h0000_0001, 7'h01},
		'{2'h2, 2'h0, 1'h1, 7'h7f, 32'h9abc_def0, 7'h20}};
	logic        clk_sys_in = 1'b0, sys_rst_in = 1'b1, req_valid_in = 1'b0, clr = 1'b1;
	logic        req_bits_en_in = 1'b0, req_delay_en_in = 1'b0;
	logic [31:0] req_data_in = 32'h0, rx_word;
	logic [1:0]  req_option_in = 2'h0;
	src_size_e   req_size_in = SIZE_8;
	logic [6:0]  req_bits_in = 7'h00, rx_cnt;
	logic [15:0] req_delay_us_in = 16'h0;
	logic        req_ready_out, sdata_out, sclk_out, busy_out, done_out;
	logic [63:0] m;
	int          bad_count = 0, cmp_count = 0, c;
	shift_out u_shift_out (.clk_sys_in, .sys_rst_in, .req_valid_in, .req_ready_out, .req_data_in,
		.req_option_in, .req_size_in, .req_bits_en_in, .req_bits_in, .req_delay_en_in,
		.req_delay_us_in, .sdata_out, .sclk_out, .busy_out, .done_out);
	shift_rx_model u_shift_rx_model (.clk_sys_in, .clr_in(clr), .option_in(req_option_in),
		.sclk_in(sclk_out), .sdata_in(sdata_out), .word_out(rx_word), .cnt_out(rx_cnt));
	task automatic close_out();
		if (bad_count == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic send(input row_s r, input logic den, input logic [15:0] us);
		logic rdy;
		@(posedge clk_sys_in);
		req_valid_in    <= 1'b1;
		req_option_in   <= r.opt;
		req_size_in     <= src_size_e'(r.size);
		req_bits_en_in  <= r.ben;
		req_bits_in     <= r.bits;
		req_data_in     <= r.data;
		req_delay_en_in <= den;
		req_delay_us_in <= us;
		do
		begin
			@(negedge clk_sys_in);
			rdy = req_ready_out;
			@(posedge clk_sys_in);
		end
		while (rdy !== 1'b1);
		req_valid_in <= 1'b0;
	endtask
	task automatic wait_done();
		c = 0;
		do
		begin
			@(negedge clk_sys_in);
			c++;
		end
		while (done_out !== 1'b1 && c < 2000);
	endtask
	task automatic clear_rx();
		@(posedge clk_sys_in) clr <= 1'b1;
		@(posedge clk_sys_in) clr <= 1'b0;
	endtask
	task automatic check(input row_s r);
		m = (64'h1 << r.n) - 64'h1;
		`CHK("count", r.n, rx_cnt)
		`CHK("word", r.opt[1] ? (r.data & m[31:0]) << (7'd32 - r.n) : r.data & m[31:0], rx_word)
		`CHK("idle level", ~r.opt[0], sclk_out)
		`CHK("spacing", 1'b1, c >= 6 * r.n)
		`CHK("idle busy", 1'b0, busy_out)
	endtask
	initial
	begin
		forever #2.5 clk_sys_in = ~clk_sys_in;
	end
	initial
	begin
		repeat (20000) @(posedge clk_sys_in);
		bad_count++;
		close_out();
	end
	initial
	begin
		repeat (20) @(posedge clk_sys_in);
		sys_rst_in <= 1'b0;
		`CHK("reset clock", 1'b1, sclk_out)
		`CHK("reset done", 1'b0, done_out)
		foreach (rows[i])
		begin
			clear_rx();
			// odd rows enable the delay with zero, which must keep the default
			send(rows[i], i[0], 16'h0);
			wait_done();
			check(rows[i]);
			`CHK("default clock", 1'b1, c < 6 * rows[i].n + 8)
		end
		// slowed clock: one microsecond half period
		clear_rx();
		send(row_s'{2'h1, 2'h0, 1'h1, 7'h01, 32'h1, 7'h01}, 1'b1, 16'h1);
		wait_done();
		check(row_s'{2'h1, 2'h0, 1'h1, 7'h01, 32'h1, 7'h01});
		`CHK("slow clock", 1'b1, c >= 600)
		// reset in mid transfer: clock pin goes high and status goes back to idle
		send(rows[1], 1'b0, 16'h0);
		repeat (30) @(posedge clk_sys_in);
		sys_rst_in <= 1'b1;
		@(negedge clk_sys_in);
		`CHK("mid reset busy", 1'b0, busy_out)
		`CHK("mid reset clock", 1'b1, sclk_out)
		`CHK("mid reset ready", 1'b1, req_ready_out)
		@(posedge clk_sys_in) sys_rst_in <= 1'b0;
		clear_rx();
		send(rows[3], 1'b0, 16'h0);
		wait_done();
		check(rows[3]);
		// fill the buffer until it refuses, nothing may be lost
		clear_rx();
		repeat (3) send(rows[0], 1'b0, 16'h0);
		@(negedge clk_sys_in);
		`CHK("full", 1'b0, req_ready_out)
		// a fourth request stalls until a slot frees, then must still go out
		send(rows[0], 1'b0, 16'h0);
		repeat (3) wait_done();
		`CHK("queued bits", 7'd32, rx_cnt)
		close_out();
	end
endmodule
